/* logic/ldd_channel.sv */
`timescale 1ns/1ps
module ldd_channel
  import ldd_pkg::*;
(
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic cnt_clear_i,
  // Alignment events
  input wire logic align_i,
  input wire logic [CAUSE_W-1:0] cause_i,
  input wire logic hold_exc_i,
  // Measurement inputs
  input wire logic [AMP_W-1:0] amp_i,
  input wire logic [AMP_W-1:0] thr_i,
  input wire logic error_i,
  input wire logic [IND_W-1:0] ind_raw_i,
  // Status and diagnostics
  output logic occupied_o,
  output logic error_o,
  output logic err_hist_o,
  output logic [CNT_W-1:0] align_cnt_o,
  output logic [CNT_W-1:0] hold_cnt_o,
  output logic [AMP_W-1:0] peak_o,
  output logic [CAUSE_W-1:0] cause_o,
  output logic [IND_W-1:0] ind_o
);
  logic occ_q, occ_d, err_q, err_d, hist_q, hist_d;
  logic [CNT_W-1:0] acnt_q, acnt_d, hcnt_q, hcnt_d;
  logic [AMP_W-1:0] peak_q, peak_d;
  logic [CAUSE_W-1:0] cause_q, cause_d;
  logic [IND_W-1:0] ind_q, ind_d;
  logic clr;

  // Power-on and the clear command both wipe the counters, peak and causes; a new event still lands
  always_comb
  begin
    clr = cnt_clear_i | por_i;
    occ_d = occ_q;
    if (amp_i > thr_i) occ_d = 1'b1;
    else if (amp_i < thr_i) occ_d = 1'b0;
    err_d = error_i;
    hist_d = (por_i ? 1'b0 : hist_q) | error_i;
    acnt_d = (clr ? '0 : acnt_q) + CNT_W'(align_i);
    hcnt_d = (clr ? '0 : hcnt_q) + CNT_W'(hold_exc_i);
    cause_d = (clr ? '0 : cause_q) | (align_i ? cause_i : '0);
    peak_d = (clr | align_i) ? '0 : peak_q;
    if (amp_i > peak_d) peak_d = amp_i;
    ind_d = ind_raw_i - (ind_raw_i % IND_STEP_UH);
  end

  // Diagnostic registers
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      occ_q <= 1'b0;
      err_q <= 1'b0;
      hist_q <= 1'b0;
      acnt_q <= '0;
      hcnt_q <= '0;
      peak_q <= '0;
      cause_q <= '0;
      ind_q <= '0;
    end
    else
    begin
      occ_q <= occ_d;
      err_q <= err_d;
      hist_q <= hist_d;
      acnt_q <= acnt_d;
      hcnt_q <= hcnt_d;
      peak_q <= peak_d;
      cause_q <= cause_d;
      ind_q <= ind_d;
    end
  end

  assign occupied_o = occ_q;
  assign error_o = err_q;
  assign err_hist_o = hist_q;
  assign align_cnt_o = acnt_q;
  assign hold_cnt_o = hcnt_q;
  assign peak_o = peak_q;
  assign cause_o = cause_q;
  assign ind_o = ind_q;
endmodule : ldd_channel

/* logic/ldd_pkg.sv */
// Behaviour
// - Data bus baud rate is configurable, default 9600; poller must match it.
// - Hardware addressing disabled uses stored nonvolatile or newly configured bus address.
// - Changing the hardware-addressing flag performs a full detector reset.
// - LEDs switch off after turn-off time; button or service traffic restarts.
// - Turn-off time zero, the default, disables automatic LED switch-off.
// - Each channel keeps occupancy, current error and sticky error-history flags.
// - Error-history flag is cleared only by power-on reset.
// - Each channel counts every alignment since the last power-on reset.
// - Hold-time exceedances count separately and also in the total alignment count.
// - Counter reset command clears alignment, hold, amplitude and cause values.
// - Loop inductance is reported in microhenry, quantized to ten microhenry steps.
// - Amplitude above threshold signals occupied, below signals free, on LED and output.
// - Each channel holds peak detuning since its latest alignment.
// - Each channel records alignment causes as seven sticky cause bits.
// - Norm value too low during calibration restarts calibration from basic settings.
// - Double-loop partners supervise each other; malfunction aligns the whole pair.
// - Detector keeps a bit-coded reset cause and a resets-since-power-on counter; the code also clears both on the counter reset command.
// - Cycle time is sum of channel times, each the longest among synced detectors.
// - With synchronization, all detectors measure the same channel in lockstep.
// - Slaves start sync on master reset or activation, end it on deactivation.
// - After sync, indicator LEDs blink at 0.5 Hz; master opposite to slaves.
package ldd_pkg;
  localparam int NUM_CH = 4;
  localparam int CLK_HZ = 200_000_000;
  localparam int BAUD_DEF = 9600;
  localparam int BAUD_W = 16;
  localparam logic [BAUD_W-1:0] BAUD_DIV_DEF = BAUD_W'(CLK_HZ / BAUD_DEF);
  // Millisecond time base
  localparam int TICK_MS_DEF = CLK_HZ / 1000;
  localparam int MS_W = 18;
  localparam int MS_PER_S = 1000;
  localparam int SEC_W = 10;
  // Indicator blink: 0.5 Hz, given in tenths of a hertz
  localparam int BLINK_HZ_X10 = 5;
  localparam int BLINK_HALF_MS = 10_000 / (2 * BLINK_HZ_X10);
  // Sync line low pulse widths in ms and the slave decode thresholds
  localparam logic [2:0] SYNC_STEP_MS = 3'h1;
  localparam logic [2:0] SYNC_CH0_MS = 3'h3;
  localparam logic [2:0] SYNC_RST_MS = 3'h6;
  localparam logic [2:0] SYNC_CH0_DET = SYNC_CH0_MS - 3'h1;
  localparam logic [2:0] SYNC_RST_DET = SYNC_RST_MS - 3'h1;
  localparam logic [7:0] SYNC_LOSS_MS = 8'h64;
  // Data widths
  localparam int AMP_W = 16;
  localparam int CNT_W = 16;
  localparam int IND_W = 16;
  localparam int MT_W = 8;
  localparam int CYC_W = MT_W + 2;
  localparam int ADDR_W = 8;
  localparam logic [IND_W-1:0] IND_STEP_UH = 16'h000A;
  localparam logic [AMP_W-1:0] NORM_MIN_DEF = 16'h0020;
  // Alignment cause bit positions
  localparam int CA_MEAS = 0;
  localparam int CA_NORM = 1;
  localparam int CA_PARTNER = 2;
  localparam int CA_HOLD = 3;
  localparam int CA_USER = 4;
  localparam int CA_SYNC = 5;
  localparam int CA_DLMON = 6;
  localparam int CAUSE_W = 7;
  // Reset cause bit positions
  localparam int RC_POR = 0;
  localparam int RC_FLAG = 1;
  localparam int RC_W = 2;
endpackage : ldd_pkg

/* logic/ldd_top.sv */
`timescale 1ns/1ps
module ldd_top
  import ldd_pkg::*;
#(
  parameter int TICK_MS_CYC = TICK_MS_DEF,
  parameter logic [AMP_W-1:0] NORM_MIN = NORM_MIN_DEF
)
(
  // Clock and resets
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic cnt_clear_i,
  // Data bus baud setting
  input wire logic [BAUD_W-1:0] baud_div_i,
  input wire logic baud_set_i,
  output logic baud_tick_o,
  // Detector flags and addressing
  input wire logic master_req_i,
  input wire logic hw_addr_en_i,
  input wire logic [2:0] dip_addr_i,
  input wire logic [ADDR_W-1:0] nv_addr_i,
  input wire logic [ADDR_W-1:0] addr_param_i,
  input wire logic addr_param_we_i,
  output logic [ADDR_W-1:0] bus_addr_o,
  output logic det_reset_o,
  output logic [RC_W-1:0] reset_cause_o,
  output logic [CNT_W-1:0] reset_cnt_o,
  // LEDs
  input wire logic [15:0] led_off_time_i,
  input wire logic button_i,
  input wire logic svc_activity_i,
  output logic leds_on_o,
  output logic function_indicator_led_o,
  output logic [NUM_CH-1:0] ch_led_o,
  // Channel measurement inputs
  input wire logic [NUM_CH-1:0][AMP_W-1:0] amp_i,
  input wire logic [NUM_CH-1:0][AMP_W-1:0] thr_i,
  input wire logic [NUM_CH-1:0][AMP_W-1:0] norm_i,
  input wire logic [NUM_CH-1:0] calib_done_i,
  input wire logic [NUM_CH-1:0] error_i,
  input wire logic [NUM_CH-1:0] meas_exc_i,
  input wire logic [NUM_CH-1:0] hold_exc_i,
  input wire logic [NUM_CH-1:0] stuck_i,
  input wire logic [NUM_CH-1:0] align_busy_i,
  input wire logic user_align_i,
  input wire logic [NUM_CH-1:0][IND_W-1:0] ind_raw_i,
  input wire logic [NUM_CH-1:0][MT_W-1:0] meas_time_i,
  input wire logic [NUM_CH-1:0][MT_W-1:0] sync_meas_max_i,
  // Channel outputs and diagnostics
  output logic [NUM_CH-1:0] switch_o,
  output logic [NUM_CH-1:0] occupied_o,
  output logic [NUM_CH-1:0] error_o,
  output logic [NUM_CH-1:0] err_hist_o,
  output logic [NUM_CH-1:0] align_o,
  output logic [NUM_CH-1:0] restart_cal_o,
  output logic [NUM_CH-1:0][CNT_W-1:0] align_cnt_o,
  output logic [NUM_CH-1:0][CNT_W-1:0] hold_cnt_o,
  output logic [NUM_CH-1:0][AMP_W-1:0] peak_o,
  output logic [NUM_CH-1:0][CAUSE_W-1:0] cause_o,
  output logic [NUM_CH-1:0][IND_W-1:0] ind_o,
  output logic [CYC_W-1:0] cycle_time_o,
  // Synchronization line (open drain)
  input wire logic sync_line_i,
  output logic sync_line_o,
  output logic sync_line_oe_o,
  output logic sync_active_o,
  output logic [1:0] cur_ch_o
);
  function automatic logic [MT_W-1:0] ldd_max(input logic [MT_W-1:0] a, input logic [MT_W-1:0] b);
    ldd_max = (a > b) ? a : b;
  endfunction : ldd_max

  // Pin synchronisers: the first stage feeds only the second
  logic sl_s1_q, sl_s2_q, btn_s1_q, btn_s2_q;
  logic [2:0] dip_s1_q, dip_s2_q;
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      sl_s1_q <= 1'b1;
      sl_s2_q <= 1'b1;
      btn_s1_q <= 1'b0;
      btn_s2_q <= 1'b0;
      dip_s1_q <= 3'h0;
      dip_s2_q <= 3'h0;
    end
    else
    begin
      sl_s1_q <= sync_line_i;
      sl_s2_q <= sl_s1_q;
      btn_s1_q <= button_i;
      btn_s2_q <= btn_s1_q;
      dip_s1_q <= dip_addr_i;
      dip_s2_q <= dip_s1_q;
    end
  end

  // Time base: baud divider, ms tick, second tick
  logic [BAUD_W-1:0] bdiv_q, bdiv_d, bcnt_q, bcnt_d;
  logic [MS_W-1:0] ms_q, ms_d;
  logic [SEC_W-1:0] sec_q, sec_d;
  logic baud_tick, ms_tick, sec_tick, wake, start_m;
  always_comb
  begin
    baud_tick = (bcnt_q >= bdiv_q - 16'h0001);
    ms_tick = (ms_q == MS_W'(TICK_MS_CYC - 1));
    sec_tick = ms_tick && (sec_q == SEC_W'(MS_PER_S - 1));
    bdiv_d = baud_set_i ? baud_div_i : bdiv_q;
    bcnt_d = (baud_set_i || baud_tick) ? '0 : bcnt_q + 16'h0001;
    ms_d = (ms_tick || start_m) ? '0 : ms_q + 18'h00001;
    sec_d = (sec_tick || wake) ? '0 : sec_q + SEC_W'(ms_tick);
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bdiv_q <= BAUD_DIV_DEF;
      bcnt_q <= '0;
      ms_q <= '0;
      sec_q <= '0;
    end
    else
    begin
      bdiv_q <= bdiv_d;
      bcnt_q <= bcnt_d;
      ms_q <= ms_d;
      sec_q <= sec_d;
    end
  end
  assign baud_tick_o = baud_tick;

  // Flags, addressing and reset bookkeeping
  logic hw_en_q, hw_en_d, init_q, rst_q, rst_d;
  logic [ADDR_W-1:0] st_addr_q, st_addr_d, addr_q, addr_d;
  logic [RC_W-1:0] rc_q, rc_d;
  logic [CNT_W-1:0] rcnt_q, rcnt_d;
  always_comb
  begin
    hw_en_d = hw_addr_en_i;
    rst_d = init_q && (hw_addr_en_i != hw_en_q);
    st_addr_d = st_addr_q;
    if (!init_q) st_addr_d = nv_addr_i;
    if (addr_param_we_i) st_addr_d = addr_param_i;
    // Switch address 0 means hardware addressing is off anyway
    addr_d = (hw_en_q && dip_s2_q != 3'h0) ? ADDR_W'(dip_s2_q) : st_addr_q;
    rc_d = (cnt_clear_i || por_i) ? '0 : rc_q;
    rcnt_d = (cnt_clear_i || por_i) ? '0 : rcnt_q;
    if (por_i) rc_d[RC_POR] = 1'b1;
    if (rst_q)
    begin
      rc_d = '0;
      rc_d[RC_FLAG] = 1'b1;
      rcnt_d = rcnt_d + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      hw_en_q <= 1'b0;
      init_q <= 1'b0;
      rst_q <= 1'b0;
      st_addr_q <= '0;
      addr_q <= '0;
      rc_q <= '0;
      rcnt_q <= '0;
    end
    else
    begin
      hw_en_q <= hw_en_d;
      init_q <= 1'b1;
      rst_q <= rst_d;
      st_addr_q <= st_addr_d;
      addr_q <= addr_d;
      rc_q <= rc_d;
      rcnt_q <= rcnt_d;
    end
  end
  assign bus_addr_o = addr_q;
  assign det_reset_o = rst_q;
  assign reset_cause_o = rc_q;
  assign reset_cnt_o = rcnt_q;

  // LED turn-off timer
  logic btn_prev_q, leds_q, leds_d;
  logic [15:0] lsec_q, lsec_d;
  always_comb
  begin
    wake = (btn_s2_q && !btn_prev_q) || svc_activity_i;
    leds_d = leds_q;
    lsec_d = lsec_q;
    if (wake || led_off_time_i == 16'h0000)
    begin
      leds_d = 1'b1;
      lsec_d = '0;
    end
    else if (sec_tick && leds_q)
    begin
      if (lsec_q + 16'h0001 >= led_off_time_i) leds_d = 1'b0;
      else lsec_d = lsec_q + 16'h0001;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      btn_prev_q <= 1'b0;
      leds_q <= 1'b1;
      lsec_q <= '0;
    end
    else
    begin
      btn_prev_q <= btn_s2_q;
      leds_q <= leds_d;
      lsec_q <= lsec_d;
    end
  end
  assign leds_on_o = leds_q;

  // Slot terms: with sync on, each channel slot takes the group's longest time
  logic [NUM_CH-1:0][MT_W-1:0] term;
  logic [CYC_W-1:0] cyc;
  logic master_q, synced_q;
  always_comb
  begin
    cyc = '0;
    for (int c = 0; c < NUM_CH; c++)
    begin
      term[c] = (master_q || synced_q) ? ldd_max(meas_time_i[c], sync_meas_max_i[c])
                                       : meas_time_i[c];
      cyc = cyc + CYC_W'(term[c]);
    end
  end
  assign cycle_time_o = cyc;

  // Sequencer and sync line: master pulses low per step, slaves follow its edges
  logic master_d, synced_d, prev_q, fall, start_s, rst_mark, loss;
  logic sync_align, blink_sync;
  logic [1:0] cur_q, cur_d;
  logic [MT_W-1:0] slot_q, slot_d;
  logic [2:0] drv_q, drv_d, low_q, low_d;
  logic [7:0] loss_q, loss_d;
  always_comb
  begin
    // A synced slave cannot become master, so only one role drives
    master_d = master_req_i && (master_q || !synced_q);
    start_m = master_d && (!master_q || rst_q);
    fall = prev_q && !sl_s2_q && !master_q;
    low_d = (sl_s2_q || master_q) ? 3'h0 : low_q + 3'(ms_tick && low_q != SYNC_RST_MS);
    rst_mark = synced_q && ms_tick && !sl_s2_q && low_q == SYNC_RST_DET - 3'h1;
    loss = synced_q && loss_q >= SYNC_LOSS_MS;
    start_s = fall && !synced_q;
    synced_d = master_d ? 1'b0 : ((synced_q && !loss) || start_s);
    loss_d = (fall || !synced_q) ? '0 : loss_q + 8'(ms_tick);
    sync_align = start_m || start_s || rst_mark || loss;
    blink_sync = start_m || start_s || rst_mark;
    cur_d = cur_q;
    slot_d = slot_q;
    drv_d = master_d ? drv_q - 3'(ms_tick && drv_q != 3'h0) : 3'h0;
    if (start_m)
    begin
      cur_d = 2'h0;
      slot_d = '0;
      drv_d = SYNC_RST_MS;
    end
    else if (synced_q)
    begin
      slot_d = '0;
      if (fall) cur_d = cur_q + 2'h1;
      if (ms_tick && !sl_s2_q && low_q == SYNC_CH0_DET - 3'h1) cur_d = 2'h0;
    end
    else if (ms_tick)
    begin
      // Master holds its slot until its own pulse ends so no edge merges
      if (slot_q + 8'h01 >= term[cur_q] && drv_q == 3'h0)
      begin
        cur_d = cur_q + 2'h1;
        slot_d = '0;
        if (master_q) drv_d = (cur_d == 2'h0) ? SYNC_CH0_MS : SYNC_STEP_MS;
      end
      else slot_d = slot_q + 8'h01;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      master_q <= 1'b0;
      synced_q <= 1'b0;
      prev_q <= 1'b1;
      cur_q <= 2'h0;
      slot_q <= '0;
      drv_q <= 3'h0;
      low_q <= 3'h0;
      loss_q <= '0;
    end
    else
    begin
      master_q <= master_d;
      synced_q <= synced_d;
      prev_q <= sl_s2_q;
      cur_q <= cur_d;
      slot_q <= slot_d;
      drv_q <= drv_d;
      low_q <= low_d;
      loss_q <= loss_d;
    end
  end
  assign sync_line_o = 1'b0;
  assign sync_line_oe_o = master_q && drv_q != 3'h0;
  assign sync_active_o = master_q || synced_q;
  assign cur_ch_o = cur_q;

  // Indicator blink, phase restarted by every sync start so all units agree
  logic [SEC_W-1:0] bl_q, bl_d;
  logic ph_q, ph_d, function_indicator_led;
  always_comb
  begin
    bl_d = bl_q;
    ph_d = ph_q;
    if (blink_sync)
    begin
      bl_d = '0;
      ph_d = 1'b0;
    end
    else if (ms_tick)
    begin
      if (bl_q == SEC_W'(BLINK_HALF_MS - 1))
      begin
        bl_d = '0;
        ph_d = !ph_q;
      end
      else bl_d = bl_q + 10'h001;
    end
    function_indicator_led = 1'b1;
    if ((master_q || synced_q) && align_busy_i == '0) function_indicator_led = ph_q ^ master_q;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (reset_i)
    begin
      bl_q <= '0;
      ph_q <= 1'b0;
    end
    else
    begin
      bl_q <= bl_d;
      ph_q <= ph_d;
    end
  end
  assign function_indicator_led_o = function_indicator_led && leds_q;

  // Per-channel alignment requests and diagnostics
  for (genvar c = 0; c < NUM_CH; c++)
  begin : g_ch
    localparam int P = c ^ 1;
    logic [CAUSE_W-1:0] cv;
    logic norm_low;
    assign norm_low = calib_done_i[c] && norm_i[c] < NORM_MIN;
    assign restart_cal_o[c] = norm_low;
    always_comb
    begin
      cv = '0;
      cv[CA_MEAS] = meas_exc_i[c];
      cv[CA_NORM] = norm_low;
      cv[CA_PARTNER] = meas_exc_i[P];
      cv[CA_HOLD] = hold_exc_i[c];
      cv[CA_USER] = user_align_i || rst_q;
      cv[CA_SYNC] = sync_align;
      cv[CA_DLMON] = stuck_i[c] || stuck_i[P];
    end
    assign align_o[c] = cv != '0;
    assign switch_o[c] = occupied_o[c];
    assign ch_led_o[c] = occupied_o[c] && leds_q;
    ldd_channel u_ch (
      .ref_clk_i(ref_clk_i),
      .reset_i(reset_i),
      .por_i(por_i),
      .cnt_clear_i(cnt_clear_i),
      .align_i(cv != '0),
      .cause_i(cv),
      .hold_exc_i(hold_exc_i[c]),
      .amp_i(amp_i[c]),
      .thr_i(thr_i[c]),
      .error_i(error_i[c]),
      .ind_raw_i(ind_raw_i[c]),
      .occupied_o(occupied_o[c]),
      .error_o(error_o[c]),
      .err_hist_o(err_hist_o[c]),
      .align_cnt_o(align_cnt_o[c]),
      .hold_cnt_o(hold_cnt_o[c]),
      .peak_o(peak_o[c]),
      .cause_o(cause_o[c]),
      .ind_o(ind_o[c])
    );
  end
endmodule : ldd_top

/* verif/ldd_sva.sv */
`timescale 1ns/1ps
module ldd_sva
  import ldd_pkg::*;
#(
  parameter int TICK_MS_CYC = TICK_MS_DEF,
  parameter logic [AMP_W-1:0] NORM_MIN = NORM_MIN_DEF
)
(
  // Clock and controls
  input wire logic ref_clk_i,
  input wire logic reset_i,
  input wire logic por_i,
  input wire logic cnt_clear_i,
  input wire logic hw_addr_en_i,
  input wire logic [15:0] led_off_time_i,
  // Channel inputs
  input wire logic [NUM_CH-1:0][AMP_W-1:0] amp_i,
  input wire logic [NUM_CH-1:0][AMP_W-1:0] thr_i,
  input wire logic [NUM_CH-1:0][AMP_W-1:0] norm_i,
  input wire logic [NUM_CH-1:0] calib_done_i,
  input wire logic [NUM_CH-1:0] meas_exc_i,
  input wire logic [NUM_CH-1:0] hold_exc_i,
  input wire logic [NUM_CH-1:0][MT_W-1:0] meas_time_i,
  // Watched outputs
  input wire logic det_reset_o,
  input wire logic [RC_W-1:0] reset_cause_o,
  input wire logic [CNT_W-1:0] reset_cnt_o,
  input wire logic leds_on_o,
  input wire logic [NUM_CH-1:0] occupied_o,
  input wire logic [NUM_CH-1:0] err_hist_o,
  input wire logic [NUM_CH-1:0] align_o,
  input wire logic [NUM_CH-1:0] restart_cal_o,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] align_cnt_o,
  input wire logic [NUM_CH-1:0][CNT_W-1:0] hold_cnt_o,
  input wire logic [NUM_CH-1:0][CAUSE_W-1:0] cause_o,
  input wire logic [NUM_CH-1:0][IND_W-1:0] ind_o,
  input wire logic [CYC_W-1:0] cycle_time_o,
  input wire logic sync_active_o
);
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (reset_i);

  // Flag change must be followed by a detector reset within a few edges
  sequence flag_flip;
    hw_addr_en_i != $past(hw_addr_en_i);
  endsequence
  sequence reset_pulse;
    ##[1:3] det_reset_o;
  endsequence

  occ_set_a: assert property (amp_i[0] > thr_i[0] |=> occupied_o[0])
    else $error("occupancy not set above threshold");
  pair_align_a: assert property (meas_exc_i[0] |-> align_o[0] && align_o[1])
    else $error("pair not aligned together");
  cnt_step_a: assert property (align_o[0] && !cnt_clear_i && !por_i |=>
    align_cnt_o[0] == $past(align_cnt_o[0]) + 16'h0001)
    else $error("alignment count did not step");
  hold_step_a: assert property (hold_exc_i[2] && !cnt_clear_i && !por_i |=>
    hold_cnt_o[2] == $past(hold_cnt_o[2]) + 16'h0001)
    else $error("hold count did not step");
  cnt_clear_a: assert property (cnt_clear_i && !align_o[0] |=>
    align_cnt_o[0] == 16'h0000 && hold_cnt_o[0] == 16'h0000 && cause_o[0] == 7'h00)
    else $error("counter reset ignored");
  hist_keep_a: assert property (err_hist_o[1] && !por_i |=> err_hist_o[1])
    else $error("error history lost without power-on");
  ind_step_a: assert property ((ind_o[0] % IND_STEP_UH) == 16'h0000)
    else $error("inductance not on step grid");
  led_stay_a: assert property (led_off_time_i == 16'h0000 && leds_on_o |=> leds_on_o)
    else $error("LEDs off with switch-off disabled");
  flag_rst_a: assert property (flag_flip |-> reset_pulse)
    else $error("no detector reset after flag change");
  rc_step_a: assert property (det_reset_o |=>
    reset_cnt_o == $past(reset_cnt_o) + 16'h0001 && reset_cause_o[RC_FLAG])
    else $error("reset count or cause wrong");
  cyc_sum_a: assert property (!sync_active_o |-> cycle_time_o ==
    CYC_W'(meas_time_i[0]) + CYC_W'(meas_time_i[1]) + CYC_W'(meas_time_i[2])
    + CYC_W'(meas_time_i[3]))
    else $error("cycle time not channel sum");
  recal_a: assert property (calib_done_i[0] && norm_i[0] < NORM_MIN |-> restart_cal_o[0])
    else $error("low norm did not restart calibration");
endmodule : ldd_sva

bind ldd_top ldd_sva #(.TICK_MS_CYC(TICK_MS_CYC), .NORM_MIN(NORM_MIN)) u_sva (.*);

/* verif/ldd_sync_peer.sv */
`timescale 1ns/1ps
// Peer detector on the shared open-drain sync line, acting as the one master
module ldd_sync_peer
(
  // Clock
  input wire logic ref_clk_i,
  // High while the peer pulls the line low
  output logic peer_oe_o
);
  initial peer_oe_o = 1'b0;

  // Pull low for whole cycles, then release to the pull-up so no stale level lingers
  task automatic pull_low(input int cyc_n);
    @(posedge ref_clk_i);
    #1;
    peer_oe_o = 1'b1;
    repeat (cyc_n) @(posedge ref_clk_i);
    #1;
    peer_oe_o = 1'b0;
  endtask : pull_low
endmodule : ldd_sync_peer

/* verif/ldd_top_bench.sv */
`timescale 1ns/1ps
module ldd_top_bench
  import ldd_pkg::*;
;
  localparam int TMS = 10;
  localparam int SEC = 1000 * TMS;
  // Design ports and bench state
  logic ref_clk_i = 1'b0;
  logic reset_i, por_i, cnt_clear_i, baud_set_i, baud_tick_o, master_req_i, hw_addr_en_i;
  logic addr_param_we_i, det_reset_o, button_i, svc_activity_i, leds_on_o, user_align_i;
  logic function_indicator_led_o, sync_line_i, sync_line_o, sync_line_oe_o, sync_active_o;
  logic peer_oe;
  logic [1:0] cur_ch_o;
  logic [2:0] dip_addr_i;
  logic [BAUD_W-1:0] baud_div_i;
  logic [ADDR_W-1:0] nv_addr_i, addr_param_i, bus_addr_o;
  logic [RC_W-1:0] reset_cause_o;
  logic [CNT_W-1:0] reset_cnt_o, n0;
  logic [15:0] led_off_time_i;
  logic [NUM_CH-1:0] ch_led_o, calib_done_i, error_i, meas_exc_i, hold_exc_i, stuck_i;
  logic [NUM_CH-1:0] align_busy_i, switch_o, occupied_o, error_o, err_hist_o, align_o;
  logic [NUM_CH-1:0] restart_cal_o;
  logic [NUM_CH-1:0][AMP_W-1:0] amp_i, thr_i, norm_i, peak_o;
  logic [NUM_CH-1:0][CNT_W-1:0] align_cnt_o, hold_cnt_o;
  logic [NUM_CH-1:0][CAUSE_W-1:0] cause_o;
  logic [NUM_CH-1:0][IND_W-1:0] ind_raw_i, ind_o;
  logic [NUM_CH-1:0][MT_W-1:0] meas_time_i, sync_meas_max_i;
  logic [CYC_W-1:0] cycle_time_o;
  int mismatches = 0;
  int n_compared = 0;
  int cycles = 0;
  int n;

  // Open-drain wire: pull-up wins unless a party pulls low
  assign sync_line_i = !((sync_line_oe_o && !sync_line_o) || peer_oe);
  // Clock
  always #2.5 ref_clk_i = ~ref_clk_i;

  ldd_top #(.TICK_MS_CYC(TMS)) dut (.*);
  ldd_sync_peer u_peer (.ref_clk_i(ref_clk_i), .peer_oe_o(peer_oe));

  // Step to just after a rising edge so drives never race the sampling edge
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
    #1;
  endtask : cyc

  task automatic chk(input logic ok, input string msg);
    n_compared++;
    if (ok !== 1'b1)
    begin
      mismatches++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask : chk

  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  task automatic t_basic();
    chk(bus_addr_o === 8'h15, "stored address");
    chk(cycle_time_o === 10'h008, "cycle time");
    chk(ind_o[0] === 16'h0122, "inductance step");
    baud_div_i = 16'h0010;
    baud_set_i = 1'b1;
    cyc(1);
    baud_set_i = 1'b0;
    for (n = 0; n < 40 && baud_tick_o !== 1'b1; n++)
      cyc(1);
    cyc(1);
    for (n = 1; n < 40 && baud_tick_o !== 1'b1; n++)
      cyc(1);
    chk(n == 16, "baud tick spacing");
  endtask : t_basic

  task automatic t_chan();
    amp_i[0] = 16'h0050;
    cyc(1);
    chk(occupied_o[0] === 1'b1 && {switch_o[0], ch_led_o[0]} === 2'h3, "occupied");
    amp_i[0] = 16'h0010;
    cyc(1);
    chk(occupied_o[0] === 1'b0 && peak_o[0] === 16'h0050, "free, peak");
    amp_i[0] = 16'h0000;
    meas_exc_i[0] = 1'b1;
    #1;
    chk(align_o[1:0] === 2'h3, "pair align");
    cyc(1);
    meas_exc_i[0] = 1'b0;
    chk(align_cnt_o[0] === 16'h0001 && peak_o[0] === 16'h0000, "count, peak");
    chk(cause_o[0][CA_MEAS] === 1'b1 && cause_o[1][CA_PARTNER] === 1'b1, "cause");
    hold_exc_i[2] = 1'b1;
    cyc(1);
    hold_exc_i[2] = 1'b0;
    chk(hold_cnt_o[2] === 16'h0001 && align_cnt_o[2] === 16'h0001, "hold count");
    stuck_i[3] = 1'b1;
    #1;
    chk(align_o[3:2] === 2'h3, "stuck pair align");
    cyc(1);
    stuck_i[3] = 1'b0;
    chk((cause_o[2][CA_DLMON] & cause_o[3][CA_DLMON]) === 1'b1, "monitor cause");
    user_align_i = 1'b1;
    cyc(1);
    user_align_i = 1'b0;
    chk(cause_o[0][CA_USER] === 1'b1 && align_cnt_o[0] === 16'h0002, "user");
    cnt_clear_i = 1'b1;
    cyc(1);
    cnt_clear_i = 1'b0;
    chk(align_cnt_o[0] === 16'h0000 && hold_cnt_o[2] === 16'h0000, "clear");
    chk(cause_o[0] === 7'h00, "cause clear");
    norm_i[1] = 16'h0010;
    calib_done_i[1:0] = 2'h3;
    #1;
    chk(restart_cal_o[1:0] === 2'h2, "calibration restart");
    cyc(1);
    calib_done_i[1:0] = 2'h0;
  endtask : t_chan

  task automatic t_err();
    error_i[1] = 1'b1;
    cyc(2);
    chk(error_o[1] === 1'b1 && err_hist_o[1] === 1'b1, "error flags");
    error_i[1] = 1'b0;
    cnt_clear_i = 1'b1;
    cyc(1);
    cnt_clear_i = 1'b0;
    cyc(1);
    chk(error_o[1] === 1'b0 && err_hist_o[1] === 1'b1, "history kept");
    por_i = 1'b1;
    cyc(1);
    por_i = 1'b0;
    cyc(1);
    chk(err_hist_o[1] === 1'b0 && reset_cause_o[RC_POR] === 1'b1, "power-on");
  endtask : t_err

  task automatic t_flag();
    n0 = reset_cnt_o;
    hw_addr_en_i = 1'b1;
    for (n = 0; n < 8 && det_reset_o !== 1'b1; n++)
      cyc(1);
    chk(det_reset_o === 1'b1 && align_o === 4'hF, "flag reset");
    cyc(1);
    chk(reset_cnt_o === n0 + 16'h0001 && reset_cause_o === 2'h2, "reset count");
    cyc(4);
    chk(bus_addr_o === 8'h03, "switch address");
    hw_addr_en_i = 1'b0;
    cyc(6);
    addr_param_i = 8'h42;
    addr_param_we_i = 1'b1;
    cyc(1);
    addr_param_we_i = 1'b0;
    cyc(1);
    chk(bus_addr_o === 8'h42, "parameter address");
  endtask : t_flag

  task automatic t_sync();
    u_peer.pull_low(6 * TMS);
    cyc(3 * TMS);
    chk(sync_active_o === 1'b1 && cause_o[0][CA_SYNC] === 1'b1, "sync start");
    u_peer.pull_low(3 * TMS);
    cyc(2 * TMS);
    chk(cur_ch_o === 2'h0 && function_indicator_led_o === 1'b0, "channel zero");
    u_peer.pull_low(TMS);
    cyc(TMS);
    chk(cur_ch_o === 2'h1, "channel step");
    cyc(110 * TMS);
    chk(sync_active_o === 1'b0, "sync end");
    master_req_i = 1'b1;
    for (n = 0; n < 20 && sync_line_oe_o !== 1'b1; n++)
      cyc(1);
    for (n = 0; n < 10 * TMS && sync_line_oe_o === 1'b1; n++)
      cyc(1);
    chk(n >= 6 * TMS - 2 && n <= 6 * TMS + 2, "master start mark");
    master_req_i = 1'b0;
  endtask : t_sync

  task automatic t_led();
    cyc(SEC + 100);
    chk(leds_on_o === 1'b1, "no switch-off at zero");
    led_off_time_i = 16'h0001;
    cyc(SEC / 2);
    chk(leds_on_o === 1'b1, "early switch-off");
    for (n = 0; n < 2 * SEC && leds_on_o !== 1'b0; n++)
      cyc(1);
    chk(leds_on_o === 1'b0, "switch-off");
    button_i = 1'b1;
    cyc(4);
    button_i = 1'b0;
    cyc(4);
    chk(leds_on_o === 1'b1, "button wake");
    cyc(SEC / 2);
    svc_activity_i = 1'b1;
    cyc(1);
    svc_activity_i = 1'b0;
    cyc(SEC * 3 / 4);
    chk(leds_on_o === 1'b1, "service restart");
  endtask : t_led

  // Hang guard
  always @(posedge ref_clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 50000)
    begin
      mismatches = mismatches + 1;
      print_verdict();
    end
  end

  // Main sequence
  initial
  begin
    {reset_i, por_i, cnt_clear_i, baud_set_i, master_req_i, hw_addr_en_i} = 6'h20;
    {addr_param_we_i, button_i, svc_activity_i, user_align_i} = 4'h0;
    {calib_done_i, error_i, meas_exc_i, hold_exc_i, stuck_i, align_busy_i} = 24'h000000;
    baud_div_i = 16'h0000;
    dip_addr_i = 3'h3;
    nv_addr_i = 8'h15;
    addr_param_i = 8'h00;
    led_off_time_i = 16'h0000;
    amp_i = '0;
    thr_i = {NUM_CH{16'h0040}};
    norm_i = {NUM_CH{16'h0080}};
    ind_raw_i = {NUM_CH{16'h0125}};
    meas_time_i = {NUM_CH{8'h02}};
    sync_meas_max_i = {NUM_CH{8'h03}};
    repeat (6) @(posedge ref_clk_i);
    #1;
    reset_i = 1'b0;
    cyc(2);
    t_basic();
    t_chan();
    t_err();
    t_flag();
    t_sync();
    t_led();
    print_verdict();
  end
endmodule : ldd_top_bench
